/* File: mpoc_top.sv */
// pin-level output control of the hardware monitor, APB register slave
//
// Operation
// - config bit 5 picks non-maskable or request mode for host interrupt
// - host interrupt pin driven only while config bit 2 is one
// - after reset host interrupt pin is disabled and in request mode
// - non-maskable mode drives open-source, request mode drives open-drain
// - management interrupt open-drain, driven only when config bit 1 set
// - master reset pulled low open-drain for at least 20 ms
// - master reset pulse only once mask-2 bit 7 enables it
// - voltage-id pin four is input, or tree output in test mode
// - lower four voltage-id inputs readable by software
// - board over-temperature input is an interrupt source
// - software controls active-low open-drain power-switch drive output
// - chained interrupt passes to management output via mask bit 6, bit 1
// - chassis high latched; mask bit 7 drives line low 20 ms to clear
//
// Local design decisions: the APB slave port and the placing of the registers.
`include "mpoc_defs.svh"

module mpoc_top #(
    parameter int PULSE_CYC = (`MPOC_CLK_HZ / 1000) * `MPOC_PULSE_MS
) (
    // clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    // apb slave
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // isa decode inputs
    input wire logic [2:0] LOW_ADDRESS_BITS_I,
    input wire logic CS_N_I,
    // monitor inputs
    input wire logic [3:0] VOLTAGE_ID_INPUTS_I,
    input wire logic BOARD_OVERTEMP_INPUT_N_I,
    input wire logic CHAINED_MGMT_INTERRUPT_INPUT_N_I,
    input wire logic CONNECTIVITY_TREE_OUTPUT_I,
    // host interrupt pin: level driven plus enable, low enable drives
    output logic HOST_INT_O,
    output logic HOST_INT_OE_N_O,
    // management interrupt, open drain (output always low when driven)
    output logic MANAGEMENT_INTERRUPT_OUTPUT_O,
    output logic MANAGEMENT_INTERRUPT_OUTPUT_OE_N_O,
    // master reset, open drain
    output logic MASTER_RESET_O,
    output logic MASTER_RESET_OE_N_O,
    // power switch drive, open drain active low
    output logic POWER_SWITCH_O,
    output logic POWER_SWITCH_OE_N_O,
    // voltage id four / tree output, two-way
    input wire logic VOLTAGE_ID4_OR_TREE_OUTPUT_I,
    output logic VOLTAGE_ID4_OR_TREE_OUTPUT_O,
    output logic VOLTAGE_ID4_OR_TREE_OUTPUT_OE_N_O,
    // chassis intrusion line, open drain clear
    input wire logic CHASSIS_I,
    output logic CHASSIS_O,
    output logic CHASSIS_OE_N_O,
    // level interrupt to the local cpu
    output logic IRQ_O
);

    // ---------------------------------------------------------------
    // registers and wires
    // ---------------------------------------------------------------
    logic [7:0] cfg_q;
    logic [7:0] smimsk_q;
    logic [7:0] nmimsk_q;
    logic [3:0] ctrl_q;
    logic [3:0] stat_q;
    logic [3:0] imsk_q;
    logic chassis_q;
    logic [2:0] addr_q;
    logic cs_q;
    logic [31:0] rd_d;
    logic hit_d;
    logic wr_en;
    logic rd_en;
    logic rst_done_ev;
    logic chs_done_ev;
    logic hint_cause;
    logic smi_cause;
    mpoc_pkg::mpoc_pulse_t rst_st_q;
    mpoc_pkg::mpoc_pulse_t chs_st_q;
    logic [31:0] rst_cnt_q;
    logic [31:0] chs_cnt_q;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    // offset match used by both read and write decode
    function automatic logic ofs_is(input logic [11:0] a,
                                    input logic [11:0] o);
        ofs_is = (a == o);
    endfunction : ofs_is

    // one access cycle: no wait states, slave is always ready
    assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd_en = PSEL_I & PENABLE_I & ~PWRITE_I;

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    // configuration: reset leaves host pin off and in request mode
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
            cfg_q <= `MPOC_CFG_RST;
        else if (wr_en && ofs_is(PADDR_I, `MPOC_CFG_OFS))
            cfg_q <= PWDATA_I[7:0];
    end

    // mask registers and control bits
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            smimsk_q <= 8'h00;
            nmimsk_q <= 8'h00;
            ctrl_q <= 4'h0;
            imsk_q <= 4'h0;
        end
        else if (wr_en)
        begin
            if (ofs_is(PADDR_I, `MPOC_SMIMSK2_OFS))
                smimsk_q <= PWDATA_I[7:0];
            if (ofs_is(PADDR_I, `MPOC_NMIMSK2_OFS))
                nmimsk_q <= PWDATA_I[7:0];
            if (ofs_is(PADDR_I, `MPOC_CTRL_OFS))
                ctrl_q <= PWDATA_I[3:0];
            if (ofs_is(PADDR_I, `MPOC_IMSK_OFS))
                imsk_q <= PWDATA_I[3:0];
        end
    end

    // ---------------------------------------------------------------
    // isa decode inputs, captured for software visibility only
    // ---------------------------------------------------------------
    // address bit zero lands in bit zero
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            addr_q <= 3'h0;
            cs_q <= 1'b1;
        end
        else
        begin
            addr_q <= LOW_ADDRESS_BITS_I;
            cs_q <= CS_N_I;
        end
    end

    // ---------------------------------------------------------------
    // master reset pulse sequencer
    // ---------------------------------------------------------------
    // pulse starts only on a request with mask-2 bit 7 enabled
    // low for the full 20 ms count, cannot be cut short
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            rst_st_q <= mpoc_pkg::MPOC_IDLE;
            rst_cnt_q <= 32'h0;
        end
        else
        begin
            case (rst_st_q)
                mpoc_pkg::MPOC_IDLE:
                    if (ctrl_q[`MPOC_CTRL_SREQ] &&
                        smimsk_q[`MPOC_SMIMSK_RESET])
                    begin
                        rst_st_q <= mpoc_pkg::MPOC_PULSE;
                        rst_cnt_q <= 32'(PULSE_CYC - 1);
                    end
                mpoc_pkg::MPOC_PULSE:
                    if (rst_cnt_q == 32'h0)
                        rst_st_q <= mpoc_pkg::MPOC_IDLE;
                    else
                        rst_cnt_q <= rst_cnt_q - 32'h1;
                default:
                    rst_st_q <= mpoc_pkg::MPOC_IDLE;
            endcase
        end
    end
    assign rst_done_ev = (rst_st_q == mpoc_pkg::MPOC_PULSE) &&
                         (rst_cnt_q == 32'h0);

    // ---------------------------------------------------------------
    // chassis intrusion clear sequencer
    // ---------------------------------------------------------------
    // mask-2 bit 7 drives the line low for the 20 ms count
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            chs_st_q <= mpoc_pkg::MPOC_IDLE;
            chs_cnt_q <= 32'h0;
        end
        else
        begin
            case (chs_st_q)
                mpoc_pkg::MPOC_IDLE:
                    if (nmimsk_q[`MPOC_NMIMSK_CHASSIS])
                    begin
                        chs_st_q <= mpoc_pkg::MPOC_PULSE;
                        chs_cnt_q <= 32'(PULSE_CYC - 1);
                    end
                mpoc_pkg::MPOC_PULSE:
                    if (chs_cnt_q == 32'h0)
                        chs_st_q <= mpoc_pkg::MPOC_IDLE;
                    else
                        chs_cnt_q <= chs_cnt_q - 32'h1;
                default:
                    chs_st_q <= mpoc_pkg::MPOC_IDLE;
            endcase
        end
    end
    assign chs_done_ev = (chs_st_q == mpoc_pkg::MPOC_PULSE) &&
                         (chs_cnt_q == 32'h0);

    // chassis latch: a high level sticks until the clear pulse ends
    // a high level is ignored while the clear pulse runs, so the clear always wins
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
            chassis_q <= 1'b0;
        else if (CHASSIS_I && chs_st_q != mpoc_pkg::MPOC_PULSE)
            chassis_q <= 1'b1;
        else if (chs_done_ev)
            chassis_q <= 1'b0;
    end

    // ---------------------------------------------------------------
    // sticky event status, cleared by reading it
    // ---------------------------------------------------------------
    // over-temperature low level is an interrupt source
    // set beats the read clear, but an event seen only in the setup cycle is cleared unread
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
            stat_q <= 4'h0;
        else
        begin
            if (rd_en && ofs_is(PADDR_I, `MPOC_STAT_OFS))
                stat_q <= 4'h0;
            if (!BOARD_OVERTEMP_INPUT_N_I)
                stat_q[`MPOC_ST_BTI] <= 1'b1;
            if (!CHAINED_MGMT_INTERRUPT_INPUT_N_I)
                stat_q[`MPOC_ST_CHAIN] <= 1'b1;
            if (CHASSIS_I && chs_st_q != mpoc_pkg::MPOC_PULSE)
                stat_q[`MPOC_ST_CHASSIS] <= 1'b1;
            if (rst_done_ev)
                stat_q[`MPOC_ST_RSTDONE] <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    always_comb
    begin
        rd_d = 32'h0;
        hit_d = 1'b1;
        case (PADDR_I)
            `MPOC_CFG_OFS: rd_d[7:0] = cfg_q;
            `MPOC_SMIMSK2_OFS: rd_d[7:0] = smimsk_q;
            `MPOC_NMIMSK2_OFS: rd_d[7:0] = nmimsk_q;
            `MPOC_STAT_OFS: rd_d[3:0] = stat_q;
            `MPOC_IMSK_OFS: rd_d[3:0] = imsk_q;
            // voltage-id levels, pin four, decode inputs, chassis
            `MPOC_VID_OFS: rd_d[9:0] = {chassis_q, cs_q, addr_q,
                                        VOLTAGE_ID4_OR_TREE_OUTPUT_I,
                                        VOLTAGE_ID_INPUTS_I};
            `MPOC_CTRL_OFS: rd_d[3:0] = ctrl_q;
            default: hit_d = 1'b0;
        endcase
    end

    // apb answer registered; unmapped address gives pslverr
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            PRDATA_O <= 32'h0;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
        else
        begin
            PREADY_O <= PSEL_I & ~PENABLE_I;
            PSLVERR_O <= PSEL_I & ~PENABLE_I & ~hit_d;
            PRDATA_O <= (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? rd_d : 32'h0;
        end
    end

    // ---------------------------------------------------------------
    // interrupt causes
    // ---------------------------------------------------------------
    // chained input gated by mask bit 6
    assign smi_cause = ctrl_q[`MPOC_CTRL_SREQ] |
                       (~CHAINED_MGMT_INTERRUPT_INPUT_N_I &
                        smimsk_q[`MPOC_SMIMSK_CHAIN]) |
                       ~BOARD_OVERTEMP_INPUT_N_I;
    assign hint_cause = ctrl_q[`MPOC_CTRL_HREQ] | chassis_q;

    // ---------------------------------------------------------------
    // pin drivers, all from flip-flops
    // ---------------------------------------------------------------
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            HOST_INT_O <= 1'b0;
            HOST_INT_OE_N_O <= 1'b1;
            MANAGEMENT_INTERRUPT_OUTPUT_O <= 1'b0;
            MANAGEMENT_INTERRUPT_OUTPUT_OE_N_O <= 1'b1;
        end
        else
        begin
            // mode bit 5; source drives high, drain drives low
            HOST_INT_O <= cfg_q[`MPOC_CFG_NMI_MODE];
            HOST_INT_OE_N_O <= ~(cfg_q[`MPOC_CFG_HINT_EN] & hint_cause);
            MANAGEMENT_INTERRUPT_OUTPUT_O <= 1'b0;
            // enabled only by config bit 1
            MANAGEMENT_INTERRUPT_OUTPUT_OE_N_O <=
                ~(cfg_q[`MPOC_CFG_SMI_EN] & smi_cause);
        end
    end

    // open-drain reset, power switch and chassis clear, totem-pole test pin
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            MASTER_RESET_O <= 1'b0;
            MASTER_RESET_OE_N_O <= 1'b1;
            POWER_SWITCH_O <= 1'b0;
            POWER_SWITCH_OE_N_O <= 1'b1;
            CHASSIS_O <= 1'b0;
            CHASSIS_OE_N_O <= 1'b1;
            VOLTAGE_ID4_OR_TREE_OUTPUT_O <= 1'b0;
            VOLTAGE_ID4_OR_TREE_OUTPUT_OE_N_O <= 1'b1;
            IRQ_O <= 1'b0;
        end
        else
        begin
            MASTER_RESET_O <= 1'b0;
            // pulled low during the pulse only
            MASTER_RESET_OE_N_O <= ~(rst_st_q == mpoc_pkg::MPOC_PULSE);
            POWER_SWITCH_O <= 1'b0;
            // software bit pulls the switch low
            POWER_SWITCH_OE_N_O <= ~ctrl_q[`MPOC_CTRL_PWR];
            CHASSIS_O <= 1'b0;
            // clear pulse on the intrusion line
            CHASSIS_OE_N_O <= ~(chs_st_q == mpoc_pkg::MPOC_PULSE);
            // totem-pole tree output only in test mode
            VOLTAGE_ID4_OR_TREE_OUTPUT_O <= CONNECTIVITY_TREE_OUTPUT_I;
            VOLTAGE_ID4_OR_TREE_OUTPUT_OE_N_O <= ~ctrl_q[`MPOC_CTRL_TREE];
            IRQ_O <= |(stat_q & imsk_q);
        end
    end
endmodule : mpoc_top

/* File: mpoc_defs.svh */
// register offsets, field positions, reset values and timing counts
`ifndef MPOC_DEFS_SVH
`define MPOC_DEFS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define MPOC_CFG_OFS 12'h000
`define MPOC_SMIMSK2_OFS 12'h004
`define MPOC_NMIMSK2_OFS 12'h008
`define MPOC_STAT_OFS 12'h00c
`define MPOC_IMSK_OFS 12'h010
`define MPOC_VID_OFS 12'h014
`define MPOC_CTRL_OFS 12'h018

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define MPOC_CFG_SMI_EN 1
`define MPOC_CFG_HINT_EN 2
`define MPOC_CFG_NMI_MODE 5
`define MPOC_SMIMSK_CHAIN 6
`define MPOC_SMIMSK_RESET 7
`define MPOC_NMIMSK_CHASSIS 7
`define MPOC_CTRL_PWR 0
`define MPOC_CTRL_TREE 1
`define MPOC_CTRL_HREQ 2
`define MPOC_CTRL_SREQ 3
`define MPOC_ST_BTI 0
`define MPOC_ST_CHAIN 1
`define MPOC_ST_CHASSIS 2
`define MPOC_ST_RSTDONE 3

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define MPOC_CFG_RST 8'h00
`define MPOC_PULSE_MS 20
`define MPOC_CLK_HZ 20000000

`endif

/* File: mpoc_pkg.sv */
// types shared by the pin output control block
package mpoc_pkg;
    // pulse sequencer states, one-hot
    typedef enum logic [1:0] {
        MPOC_IDLE = 2'b01,
        MPOC_PULSE = 2'b10
    } mpoc_pulse_t;
endpackage : mpoc_pkg

/* File: mpoc_assertions.sv */
// checker for the pin output control block: pin gating and pulse lengths
`include "mpoc_defs.svh"

module mpoc_assertions #(
    parameter int PULSE_CYC = 8
) (
    // clock, reset and apb
    input wire logic SYS_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic PREADY_O,
    // pins
    input wire logic HOST_INT_O,
    input wire logic HOST_INT_OE_N_O,
    input wire logic MANAGEMENT_INTERRUPT_OUTPUT_O,
    input wire logic MANAGEMENT_INTERRUPT_OUTPUT_OE_N_O,
    input wire logic MASTER_RESET_O,
    input wire logic MASTER_RESET_OE_N_O,
    input wire logic POWER_SWITCH_O,
    input wire logic POWER_SWITCH_OE_N_O,
    input wire logic VOLTAGE_ID4_OR_TREE_OUTPUT_OE_N_O,
    input wire logic CHASSIS_OE_N_O
);
    // ---------------------------------------------------------------
    // register shadows and low-time counters
    // ---------------------------------------------------------------
    logic [7:0] cfg_q, smi_q, ctrl_q;
    logic [31:0] rlo_q, clo_q;
    wire logic wr = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_N_I);
    // shadows follow committed writes only, never the setup phase
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RST_N_I)
        begin
            cfg_q <= 8'h00;
            smi_q <= 8'h00;
            ctrl_q <= 8'h00;
        end
        else if (wr && PADDR_I == `MPOC_CFG_OFS) cfg_q <= PWDATA_I[7:0];
        else if (wr && PADDR_I == `MPOC_SMIMSK2_OFS) smi_q <= PWDATA_I[7:0];
        else if (wr && PADDR_I == `MPOC_CTRL_OFS) ctrl_q <= PWDATA_I[7:0];
    end
    // counts consecutive driven cycles of the two timed pulses
    always_ff @(posedge SYS_CLK_I)
    begin
        rlo_q <= (!RST_N_I || MASTER_RESET_OE_N_O) ? 32'h0 : rlo_q + 32'h1;
        clo_q <= (!RST_N_I || CHASSIS_OE_N_O) ? 32'h0 : clo_q + 32'h1;
    end
    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    a_apb_answer:
        assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
        else $error("apb answer not a single cycle");
    a_host_gate:
        assert property (!$past(cfg_q[`MPOC_CFG_HINT_EN]) |-> HOST_INT_OE_N_O)
        else $error("host interrupt driven while disabled");
    a_host_level:
        assert property (!HOST_INT_OE_N_O |-> HOST_INT_O ==
            $past(cfg_q[`MPOC_CFG_NMI_MODE])) else $error("host level wrong");
    a_mgmt_gate:
        assert property (!$past(cfg_q[`MPOC_CFG_SMI_EN]) |->
            MANAGEMENT_INTERRUPT_OUTPUT_OE_N_O) else $error("mgmt driven");
    a_od_low:
        assert property (!(MANAGEMENT_INTERRUPT_OUTPUT_O || MASTER_RESET_O ||
            POWER_SWITCH_O)) else $error("open drain pin driven high");
    a_reset_len:
        assert property ($rose(MASTER_RESET_OE_N_O) |-> rlo_q >= PULSE_CYC)
        else $error("reset pulse too short");
    a_reset_gate:
        assert property ($fell(MASTER_RESET_OE_N_O) |->
            $past(smi_q[`MPOC_SMIMSK_RESET])) else $error("reset not enabled");
    a_chassis_len:
        assert property ($rose(CHASSIS_OE_N_O) |-> clo_q >= PULSE_CYC)
        else $error("chassis clear pulse too short");
    a_power_follow:
        assert property (POWER_SWITCH_OE_N_O == !$past(ctrl_q[`MPOC_CTRL_PWR]))
        else $error("power switch does not follow control");
    a_tree_follow:
        assert property (VOLTAGE_ID4_OR_TREE_OUTPUT_OE_N_O ==
            !$past(ctrl_q[`MPOC_CTRL_TREE])) else $error("tree enable wrong");
endmodule : mpoc_assertions

bind mpoc_top mpoc_assertions #(.PULSE_CYC(PULSE_CYC)) i_chk (
    .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .HOST_INT_O(HOST_INT_O),
    .HOST_INT_OE_N_O(HOST_INT_OE_N_O),
    .MANAGEMENT_INTERRUPT_OUTPUT_O(MANAGEMENT_INTERRUPT_OUTPUT_O),
    .MANAGEMENT_INTERRUPT_OUTPUT_OE_N_O(MANAGEMENT_INTERRUPT_OUTPUT_OE_N_O),
    .MASTER_RESET_O(MASTER_RESET_O), .MASTER_RESET_OE_N_O(MASTER_RESET_OE_N_O),
    .POWER_SWITCH_O(POWER_SWITCH_O), .POWER_SWITCH_OE_N_O(POWER_SWITCH_OE_N_O),
    .VOLTAGE_ID4_OR_TREE_OUTPUT_OE_N_O(VOLTAGE_ID4_OR_TREE_OUTPUT_OE_N_O),
    .CHASSIS_OE_N_O(CHASSIS_OE_N_O)
);

/* File: mpoc_host_model.sv */
// host-side model: isa address decode and the shared pin wires
module mpoc_host_model #(
    parameter logic [12:0] BASE = 13'h0a5
) (
    // isa address side
    input wire logic [15:0] isa_addr_i,
    input wire logic isa_sel_i,
    output logic [2:0] low_bits_o,
    output logic cs_n_o,
    // two-way pin four and chassis line
    input wire logic tree_val_i,
    input wire logic tree_oe_n_i,
    input wire logic vid4_ext_i,
    output logic pin4_line_o,
    input wire logic chassis_oe_n_i,
    input wire logic intr_i,
    output logic chassis_line_o
);
    // low address bits, bit zero lowest
    assign low_bits_o = isa_addr_i[2:0];
    // decoder of the high bits selects the device
    assign cs_n_o = !(isa_sel_i && isa_addr_i[15:3] == BASE);
    // tree driver wins the pin while enabled
    assign pin4_line_o = tree_oe_n_i ? vid4_ext_i : tree_val_i;
    // intrusion circuit drives high; the clear pulse pulls it low
    assign chassis_line_o = chassis_oe_n_i ? intr_i : 1'b0;
endmodule : mpoc_host_model

/* File: tb.sv */
// self-checking bench for the pin output control block
`include "mpoc_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PC = 8;
    localparam logic [12:0] DEC_BASE = 13'h0a5; // arbitrary decoder base
    logic clk, rst_n, psel, pen, pwr, ot_n, ch_n, tree, intr, v4, isa_sel;
    logic pready, perr, err, irq, h, h_oe, m, m_oe, r, r_oe, p, p_oe;
    logic t_o, t_oe, c_o, c_oe, c_line, v4_line, cs_n;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic [15:0] isa;
    logic [3:0] vid;
    logic [2:0] lo;
    logic [7:0] cfg, ctrl;
    int failures, n_compared, rlow, clow;
    // ---------------------------------------------------------------
    // design and far side
    // ---------------------------------------------------------------
    mpoc_top #(.PULSE_CYC(PC)) i_dut (
        .SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(perr), .LOW_ADDRESS_BITS_I(lo),
        .CS_N_I(cs_n), .VOLTAGE_ID_INPUTS_I(vid), .BOARD_OVERTEMP_INPUT_N_I(ot_n),
        .CHAINED_MGMT_INTERRUPT_INPUT_N_I(ch_n), .CONNECTIVITY_TREE_OUTPUT_I(tree),
        .HOST_INT_O(h), .HOST_INT_OE_N_O(h_oe),
        .MANAGEMENT_INTERRUPT_OUTPUT_O(m), .MANAGEMENT_INTERRUPT_OUTPUT_OE_N_O(m_oe),
        .MASTER_RESET_O(r), .MASTER_RESET_OE_N_O(r_oe), .POWER_SWITCH_O(p),
        .POWER_SWITCH_OE_N_O(p_oe), .VOLTAGE_ID4_OR_TREE_OUTPUT_I(v4_line),
        .VOLTAGE_ID4_OR_TREE_OUTPUT_O(t_o),
        .VOLTAGE_ID4_OR_TREE_OUTPUT_OE_N_O(t_oe), .CHASSIS_I(c_line),
        .CHASSIS_O(c_o), .CHASSIS_OE_N_O(c_oe), .IRQ_O(irq));
    mpoc_host_model #(.BASE(DEC_BASE)) i_host (
        .isa_addr_i(isa), .isa_sel_i(isa_sel), .low_bits_o(lo), .cs_n_o(cs_n),
        .tree_val_i(t_o), .tree_oe_n_i(t_oe), .vid4_ext_i(v4),
        .pin4_line_o(v4_line), .chassis_oe_n_i(c_oe), .intr_i(intr),
        .chassis_line_o(c_line));
    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // pulse widths measured where the pins are settled
    always @(negedge clk)
    begin
        if (r_oe === 1'b0) rlow++;
        if (c_oe === 1'b0) clow++;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : tick
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        // request stands until pready is seen high at a rising edge
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rd = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic chk_pin(input string s, input logic e, input logic g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s exp %b got %b", s, e, g);
        end
    endtask : chk_pin
    task automatic chk_reg(input string s, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask : chk_reg
    task automatic end_of_test;
        if (failures == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    initial
    begin
        {psel, pen, pwr, tree, intr, v4, isa_sel, rst_n} = 8'h00;
        {ot_n, ch_n, paddr, pwdata, isa, vid} = {2'b11, 64'h0};
        seed = 32'h4c471ffa;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk_pin("host_oe_n", 1'b1, h_oe);
        chk_pin("mgmt_oe_n", 1'b1, m_oe);
        apb(1'b0, `MPOC_CFG_OFS, 32'h0);
        chk_reg("cfg", 32'h0, rd);
        apb(1'b1, `MPOC_SMIMSK2_OFS, 32'h40);
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            cfg = {2'b00, seed[0], 2'b00, seed[1], seed[2], 1'b0};
            ctrl = {5'h00, seed[3], seed[4], seed[5]};
            {ch_n, tree, vid, isa_sel, v4} <= {seed[7:6], seed[11:8], seed[12], seed[14]};
            isa <= seed[13] ? {DEC_BASE, seed[18:16]} : seed[31:16];
            apb(1'b1, `MPOC_CFG_OFS, {24'h0, cfg});
            apb(1'b1, `MPOC_CTRL_OFS, {24'h0, ctrl});
            tick(2);
            chk_pin("host_oe_n", !(cfg[2] && ctrl[2]), h_oe);
            if (h_oe === 1'b0) chk_pin("host_lvl", cfg[5], h);
            chk_pin("mgmt_oe_n", !(cfg[1] && !ch_n), m_oe);
            if (m_oe === 1'b0) chk_pin("mgmt_lvl", 1'b0, m);
            chk_pin("pwr_oe_n", !ctrl[0], p_oe);
            chk_pin("tree_oe_n", !ctrl[1], t_oe);
            if (ctrl[1]) chk_pin("tree", tree, t_o);
            apb(1'b0, `MPOC_VID_OFS, 32'h0);
            chk_reg("vid", {23'h0, !(isa_sel && isa[15:3] == DEC_BASE), isa[2:0],
                ctrl[1] ? tree : v4, vid}, rd);
        end
        ch_n <= 1'b1;
        apb(1'b0, `MPOC_STAT_OFS, 32'h0);
        ot_n <= 1'b0;
        tick(2);
        ot_n <= 1'b1;
        tick(3);
        chk_pin("irq_masked", 1'b0, irq);
        apb(1'b1, `MPOC_IMSK_OFS, 32'h1);
        tick(2);
        chk_pin("irq", 1'b1, irq);
        apb(1'b0, `MPOC_STAT_OFS, 32'h0);
        chk_pin("stat_ot", 1'b1, rd[0]);
        tick(2);
        chk_pin("irq_clr", 1'b0, irq);
        apb(1'b1, `MPOC_CTRL_OFS, 32'h8);
        tick(PC + 4);
        chk_pin("rst_oe_n", 1'b1, r_oe);
        rlow = 0;
        apb(1'b1, `MPOC_SMIMSK2_OFS, 32'hc0);
        apb(1'b1, `MPOC_CTRL_OFS, 32'h0);
        tick(PC + 4);
        chk_reg("rst_len", PC, rlow);
        apb(1'b0, `MPOC_STAT_OFS, 32'h0);
        chk_pin("rst_done", 1'b1, rd[3]);
        intr <= 1'b1;
        tick(2);
        intr <= 1'b0;
        tick(3);
        apb(1'b0, `MPOC_VID_OFS, 32'h0);
        chk_pin("chassis_set", 1'b1, rd[9]);
        apb(1'b0, `MPOC_STAT_OFS, 32'h0);
        chk_pin("stat_chs", 1'b1, rd[2]);
        clow = 0;
        apb(1'b1, `MPOC_NMIMSK2_OFS, 32'h80);
        apb(1'b1, `MPOC_NMIMSK2_OFS, 32'h0);
        tick(PC + 4);
        chk_reg("chassis_len", PC, clow);
        chk_pin("chassis_o", 1'b0, c_o);
        apb(1'b0, `MPOC_VID_OFS, 32'h0);
        chk_pin("chassis_clr", 1'b0, rd[9]);
        apb(1'b0, 12'h01c, 32'h0);
        chk_pin("slverr", 1'b1, err);
        chk_reg("unmapped", 32'h0, rd);
        end_of_test;
    end
    // watchdog well beyond the expected run of under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        failures++;
        end_of_test;
    end
endmodule : tb
